// >>> logic/pmc_defs.svh
// Constants for the controller-side nibble interface of the PHY
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Reference clock on ref_clock_in, in MHz
`define PMC_REF_CLK_MHZ  25
// Bit positions inside the synchronised pin vector
`define PMC_SYN_TXD_LSB  0
`define PMC_SYN_TXER     4
`define PMC_SYN_TXEN     5
`define PMC_SYN_REF      6
`define PMC_SYN_WIDTH    7
// Line symbols
`define PMC_SYM_IDLE     5'h1F
`define PMC_SYM_ERROR    5'h04
// Reset values
`define PMC_RST_NIBBLE   4'h0
`define PMC_RST_SYM      5'h1F

`endif

// >>> logic/pmc_edge_sync.sv
// Two-flop synchroniser for the controller pins and reference clock
`timescale 1ns/100ps
`include "pmc_defs.svh"

module pmc_edge_sync (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    // Asynchronous pins
    input  wire logic [`PMC_SYN_WIDTH-1:0]  async_in,
    // Synchronised pins and reference clock edges
    output logic      [`PMC_SYN_WIDTH-1:0]  sync_out,
    output logic                            ref_rise,
    output logic                            ref_fall
);

    logic [`PMC_SYN_WIDTH-1:0] meta;
    logic                      ref_last;

    // The edge detector reads only the second stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta     <= '0;
            sync_out <= '0;
            ref_last <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
            ref_last <= sync_out[`PMC_SYN_REF];
        end
    end

    assign ref_rise = sync_out[`PMC_SYN_REF] & ~ref_last;
    assign ref_fall = ~sync_out[`PMC_SYN_REF] & ref_last;

endmodule // pmc_edge_sync

// >>> logic/pmc_mii_dev.sv
// Controller-facing nibble interface of the PHY, device end
// Contract
// - Transmit clock derived from 25 MHz reference
// - Transmit pins sampled on transmit clock rise
// - One nibble per clock, only while enabled
// - Transmit error sends special error pattern
// - Encoder bypass uses error as fifth bit
// - Receive outputs change on receive clock fall
// - Carrier sense follows line, on falling edges
// - Data valid follows line valid, even when decoding fails
// - One received nibble per receive clock
// - Receive error flags coding or line errors
// - Decoder bypass uses receive error as bit4
// - Collision raised when transmit meets receive
`timescale 1ns/100ps
`include "pmc_defs.svh"

module pmc_mii_dev (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    // Reference clock pin, sampled by core_clk
    input  wire logic                  ref_clock_in,
    // Static mode straps, same clock domain
    input  wire logic                  tx_bypass,
    input  wire logic                  rx_bypass,
    // Controller transmit pins
    input  wire logic [3:0]            txd,
    input  wire logic                  tx_en,
    input  wire logic                  tx_fifth_symbol_bit,
    // Controller clock and receive pins
    output logic                       tx_clk,
    output logic                       rx_clk,
    output logic [3:0]                 rxd,
    output logic                       rx_dv,
    output logic                       rx_fifth_symbol_bit,
    output logic                       crs,
    output logic                       col,
    // Line side symbol streams
    input  pmc_pkg::pmc_line_rx_s      line_rx,
    output pmc_pkg::pmc_line_tx_s      line_tx
);

    logic [`PMC_SYN_WIDTH-1:0] syn;
    logic                      ref_rise;
    logic                      ref_fall;
    logic [3:0]                s_txd;
    logic                      s_en;
    logic                      s_er;

    pmc_edge_sync u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in ({ref_clock_in, tx_en, tx_fifth_symbol_bit, txd}),
        .sync_out (syn),
        .ref_rise (ref_rise),
        .ref_fall (ref_fall)
    );

    assign s_txd = syn[`PMC_SYN_TXD_LSB +: 4];
    assign s_en  = syn[`PMC_SYN_TXEN];
    assign s_er  = syn[`PMC_SYN_TXER];

    // Clock outputs: both follow the sampled reference
    logic clk_q;
    logic next_clk_q;

    always_comb begin
        next_clk_q = clk_q;
        if (ref_rise) begin
            next_clk_q = 1'b1;
        end else if (ref_fall) begin
            next_clk_q = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= next_clk_q;
        end
    end

    assign tx_clk = clk_q;
    assign rx_clk = clk_q;

    // Transmit path
    pmc_pkg::pmc_line_tx_s tx_q;
    pmc_pkg::pmc_line_tx_s next_tx_q;

    always_comb begin
        next_tx_q = tx_q;
        // Pins synchronise faster than a reference half period, so the
        // value seen at the rise is the one the controller set up
        if (ref_rise) begin
            if (s_en) begin
                next_tx_q.valid = 1'b1;
                if (tx_bypass) begin
                    next_tx_q.sym = {s_er, s_txd};
                end else if (s_er) begin
                    next_tx_q.sym = `PMC_SYM_ERROR;
                end else begin
                    next_tx_q.sym = pmc_pkg::pmc_encode(s_txd);
                end
            end else begin
                next_tx_q.valid = 1'b0;
                next_tx_q.sym   = `PMC_SYM_IDLE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_q <= '{valid: 1'b0, sym: `PMC_RST_SYM};
        end else begin
            tx_q <= next_tx_q;
        end
    end

    assign line_tx = tx_q;

    // Receive path, updated only at the reference fall
    pmc_pkg::pmc_rx_pins_s rx_q;
    pmc_pkg::pmc_rx_pins_s next_rx_q;
    logic [4:0]            dec;

    always_comb begin
        dec       = pmc_pkg::pmc_decode(line_rx.sym);
        next_rx_q = rx_q;
        if (ref_fall) begin
            next_rx_q.crs = line_rx.carrier;
            next_rx_q.dv  = line_rx.valid;
            if (!line_rx.valid) begin
                next_rx_q.rxd = `PMC_RST_NIBBLE;
                next_rx_q.er  = 1'b0;
            end else if (rx_bypass) begin
                next_rx_q.rxd = line_rx.sym[3:0];
                next_rx_q.er  = line_rx.sym[4];
            end else begin
                next_rx_q.rxd = dec[3:0];
                next_rx_q.er  = dec[4] | line_rx.err;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_q <= '{crs: 1'b0, dv: 1'b0, er: 1'b0,
                      rxd: `PMC_RST_NIBBLE};
        end else begin
            rx_q <= next_rx_q;
        end
    end

    assign crs                 = rx_q.crs;
    assign rx_dv               = rx_q.dv;
    assign rx_fifth_symbol_bit = rx_q.er;
    assign rxd                 = rx_q.rxd;

    // Collision: own transmission overlaps line carrier (half duplex)
    logic col_q;
    logic next_col_q;

    always_comb begin
        next_col_q = tx_q.valid & line_rx.carrier;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            col_q <= 1'b0;
        end else begin
            col_q <= next_col_q;
        end
    end

    assign col = col_q;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence seq_tx_take;
        ref_rise && s_en;
    endsequence

    sequence seq_rx_good;
        ref_fall && line_rx.valid && !rx_bypass && !dec[4] && !line_rx.err;
    endsequence

    a_tx_clk_rise: assert property (ref_rise |=> tx_clk && rx_clk)
        else $error("transmit clock did not follow reference rise");
    a_tx_edge_only: assert property (
        $changed(line_tx) |-> $past(ref_rise))
        else $error("line symbol changed away from a clock rise");
    a_tx_nibble: assert property (
        seq_tx_take ##0 (!tx_bypass && !s_er)
        |=> line_tx.valid && line_tx.sym == pmc_pkg::pmc_encode($past(s_txd)))
        else $error("nibble not encoded onto the line");
    a_tx_idle: assert property (ref_rise && !s_en |=> !line_tx.valid)
        else $error("line active without transmit enable");
    a_tx_err_sym: assert property (
        seq_tx_take ##0 (!tx_bypass && s_er)
        |=> line_tx.sym == `PMC_SYM_ERROR)
        else $error("error pattern not sent");
    a_tx_bypass_sym: assert property (seq_tx_take ##0 tx_bypass
        |=> line_tx.sym == {$past(s_er), $past(s_txd)})
        else $error("bypass symbol wrong");
    a_rx_fall_only: assert property (
        $changed(rx_q) |-> $past(ref_fall))
        else $error("receive outputs changed off a falling edge");
    a_crs_follow: assert property (
        ref_fall |=> crs == $past(line_rx.carrier))
        else $error("carrier sense does not follow line");
    a_rx_decode: assert property (seq_rx_good
        |=> rx_dv && !rx_fifth_symbol_bit && rxd == $past(dec[3:0]))
        else $error("decoded nibble wrong");
    a_rx_dv_valid: assert property (
        ref_fall && !line_rx.valid |=> !rx_dv)
        else $error("data valid without line data");
    a_rx_code_err: assert property (
        ref_fall && line_rx.valid && !rx_bypass
        && dec[4] |=> rx_fifth_symbol_bit)
        else $error("coding error not flagged");
    a_rx_bypass: assert property (
        ref_fall && line_rx.valid && rx_bypass
        |=> {rx_fifth_symbol_bit, rxd} == $past(line_rx.sym))
        else $error("bypass receive symbol wrong");
    a_col_flag: assert property (
        line_tx.valid && line_rx.carrier |=> col)
        else $error("collision not raised");

endmodule // pmc_mii_dev

// >>> logic/pmc_pkg.sv
// Types and symbol coding for the controller-side nibble interface
package pmc_pkg;

    // Symbol stream toward the line transmitter
    typedef struct packed {
        logic       valid;
        logic [4:0] sym;
    } pmc_line_tx_s;

    // Symbol stream from the line receiver, same clock as the block
    typedef struct packed {
        logic       carrier;
        logic       valid;
        logic       err;
        logic [4:0] sym;
    } pmc_line_rx_s;

    // Outputs toward the controller on the receive side
    typedef struct packed {
        logic       crs;
        logic       dv;
        logic       er;
        logic [3:0] rxd;
    } pmc_rx_pins_s;

    typedef logic [4:0] pmc_sym_t;

    function automatic pmc_sym_t pmc_encode(input logic [3:0] nib);
        case (nib)
            4'h0: pmc_encode = 5'h1E;
            4'h1: pmc_encode = 5'h09;
            4'h2: pmc_encode = 5'h14;
            4'h3: pmc_encode = 5'h15;
            4'h4: pmc_encode = 5'h0A;
            4'h5: pmc_encode = 5'h0B;
            4'h6: pmc_encode = 5'h0E;
            4'h7: pmc_encode = 5'h0F;
            4'h8: pmc_encode = 5'h12;
            4'h9: pmc_encode = 5'h13;
            4'hA: pmc_encode = 5'h16;
            4'hB: pmc_encode = 5'h17;
            4'hC: pmc_encode = 5'h1A;
            4'hD: pmc_encode = 5'h1B;
            4'hE: pmc_encode = 5'h1C;
            default: pmc_encode = 5'h1D;
        endcase
    endfunction

    // Returns {bad, nibble}; bad is set for any non-data symbol
    function automatic logic [4:0] pmc_decode(input pmc_sym_t sym);
        logic [4:0] res;
        res = 5'h10;
        for (int i = 0; i < 16; i++) begin
            if (pmc_encode(4'(i)) == sym) begin
                res = {1'b0, 4'(i)};
            end
        end
        return res;
    endfunction

endpackage

// >>> verif/pmc_mac_model.sv
// Behavioural controller at the far side of the nibble interface
`timescale 1ns/100ps

module pmc_mac_model (
    // Clocks
    input  wire logic             core_clk,
    input  wire logic             tx_clk,
    input  wire logic             rx_clk,
    // Next nibble to launch
    input  wire logic [3:0]       nxt_txd,
    input  wire logic             nxt_en,
    input  wire logic             nxt_err,
    // Transmit pins and launch strobe
    output logic      [3:0]       txd,
    output logic                  tx_en,
    output logic                  tx_fifth_symbol_bit,
    output logic                  took,
    // Receive pins and their samples
    input  wire logic [3:0]       rxd,
    input  wire logic             rx_dv,
    input  wire logic             rx_fifth_symbol_bit,
    input  wire logic             crs,
    output pmc_pkg::pmc_rx_pins_s rx_cap
);
    logic tx_clk_q;

    initial begin
        {txd, tx_en, tx_fifth_symbol_bit, took, tx_clk_q} = 8'h00;
        rx_cap = '0;
    end

    // Launch just after tx_clk rises so pins are stable a whole period
    always @(negedge core_clk) begin
        tx_clk_q <= tx_clk;
        took <= tx_clk & ~tx_clk_q;
        if (tx_clk & ~tx_clk_q) begin
            tx_en <= nxt_en;
            // Invalid data is scrambled so a stale nibble cannot pass
            txd <= nxt_en ? nxt_txd : ~txd;
            tx_fifth_symbol_bit <= nxt_en ? nxt_err : ~tx_fifth_symbol_bit;
        end
    end

    always @(posedge rx_clk) begin
        rx_cap <= '{crs, rx_dv, rx_fifth_symbol_bit, rxd};
    end
endmodule // pmc_mac_model

// >>> verif/tb.sv
// Self-checking bench for the controller-side nibble interface
`timescale 1ns/100ps
`include "pmc_defs.svh"

module tb;
    typedef struct packed {
        pmc_pkg::pmc_line_tx_s tx;
        pmc_pkg::pmc_rx_pins_s rx;
        logic                  col;
        logic                  ccol;
    } pmc_tb_exp_s;

    localparam logic [4:0] SYM [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
        5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
        5'h1A, 5'h1B, 5'h1C, 5'h1D};

    logic core_clk, arst_n, ref_clock_in, tx_bypass, rx_bypass;
    logic [3:0] txd, rxd, n_txd;
    logic tx_en, tx_fifth_symbol_bit, tx_clk, rx_clk, rx_dv;
    logic rx_fifth_symbol_bit, crs, col, took, n_en, n_err;
    logic prev_en, prev_ok;
    pmc_pkg::pmc_line_rx_s line_rx;
    pmc_pkg::pmc_line_tx_s line_tx;
    pmc_pkg::pmc_rx_pins_s rx_cap;
    pmc_tb_exp_s q[$];
    pmc_tb_exp_s got;
    int n_mismatch, compares;
    time last_t;

    pmc_mii_dev dut (.core_clk(core_clk), .arst_n(arst_n),
        .ref_clock_in(ref_clock_in), .tx_bypass(tx_bypass),
        .rx_bypass(rx_bypass), .txd(txd), .tx_en(tx_en),
        .tx_fifth_symbol_bit(tx_fifth_symbol_bit), .tx_clk(tx_clk),
        .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv),
        .rx_fifth_symbol_bit(rx_fifth_symbol_bit), .crs(crs), .col(col),
        .line_rx(line_rx), .line_tx(line_tx));

    pmc_mac_model mac (.core_clk(core_clk), .tx_clk(tx_clk),
        .rx_clk(rx_clk), .nxt_txd(n_txd), .nxt_en(n_en), .nxt_err(n_err),
        .txd(txd), .tx_en(tx_en), .tx_fifth_symbol_bit(tx_fifth_symbol_bit),
        .took(took), .rxd(rxd), .rx_dv(rx_dv),
        .rx_fifth_symbol_bit(rx_fifth_symbol_bit), .crs(crs),
        .rx_cap(rx_cap));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(negedge core_clk);
        arst_n = 1'b0;
        q.delete();
        {prev_ok, last_t} = '0;
        repeat (n) @(negedge core_clk);
        chk("line_tx", {1'b0, `PMC_SYM_IDLE}, line_tx);
        chk("outputs", 16'h0000, {crs, rx_dv, rx_fifth_symbol_bit, rxd,
            col, tx_clk, rx_clk});
        arst_n = 1'b1;
    endtask

    // One period: note what the launched nibble and new line symbol give
    task automatic step(input logic bt, input logic br);
        pmc_tb_exp_s e;
        logic [4:0] d;
        int k;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (!took && k < 20);
        chk("launch", 16'h0001, {15'h0000, took});
        {tx_bypass, rx_bypass} = {bt, br};
        line_rx = 8'($urandom);
        e = '0;
        e.tx = '{1'b0, `PMC_SYM_IDLE};
        if (n_en && bt) e.tx = '{1'b1, {n_err, n_txd}};
        else if (n_en && n_err) e.tx = '{1'b1, `PMC_SYM_ERROR};
        else if (n_en) e.tx = '{1'b1, SYM[n_txd]};
        d = 5'h10;
        for (int i = 0; i < 16; i++) if (SYM[i] == line_rx.sym) d = 5'(i);
        e.rx.crs = line_rx.carrier;
        if (line_rx.valid && br) begin
            e.rx = '{line_rx.carrier, 1'b1, line_rx.sym[4], line_rx.sym[3:0]};
        end else if (line_rx.valid) begin
            e.rx = '{line_rx.carrier, 1'b1, d[4] | line_rx.err, d[3:0]};
        end
        e.col = prev_en & line_rx.carrier;
        e.ccol = prev_ok;
        q.push_back(e);
        {prev_en, prev_ok} = {n_en, 1'b1};
        {n_en, n_err, n_txd} = 6'($urandom);
    endtask

    always @(posedge tx_clk) begin
        #5;
        if (last_t != 0) begin
            chk("tx_clk period", 16'h0190, 16'($time - last_t));
        end
        last_t = $time;
        if (q.size() > 0) begin
            got = q.pop_front();
            chk("line_tx", got.tx, line_tx);
            chk("rx flags", got.rx[6:5], rx_cap[6:5]);
            chk("rx data", got.rx[4:0], rx_cap[4:0]);
            if (got.ccol) chk("col", got.col, col);
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Free-running reference, phase unrelated to core_clk
    initial begin
        ref_clock_in = 1'b0;
        #13;
        forever #200 ref_clock_in = ~ref_clock_in;
    end

    initial begin
        #200000;
        n_mismatch++;
        $display("unexpected run length expected done seen hang");
        report_and_stop();
    end

    initial begin
        {arst_n, tx_bypass, rx_bypass, n_en, n_err, n_txd} = '0;
        {prev_en, prev_ok, n_mismatch, compares, last_t} = '0;
        line_rx = '0;
        void'($urandom(61889));
        do_reset(16);
        repeat (40) step(1'b0, 1'b0);
        n_en = 1'b1;
        do_reset(3);
        repeat (40) step(1'b1, 1'b1);
        repeat (40) step(1'($urandom), 1'($urandom));
        report_and_stop();
    end
endmodule // tb
